// [logic/bsfe_exec_unit.sv]
// Execution core for bit, shift, rotate and status flag instructions.
// Assumes one decoded opcode per valid cycle from logic on the same
// clock, and that the register file and I/O space apply the write
// strobes one cycle after the opcode was taken.
`timescale 1ns/1ps

//----------------------------------------------------------------------
// Operation
//----------------------------------------------------------------------
// Operation
// - Stack pull loads destination register from stack
// - I/O bit set forces selected bit one
// - I/O bit clear forces selected bit zero
// - Left shift moves bits up, zero fill
// - Right shift moves bits down, zero fill
// - Left rotate: carry in bit0, bit7 out
// - Right rotate: carry in bit7, bit0 out
// - Arithmetic right shift keeps sign bit
// - Nibble exchange swaps high and low halves
// - Status bit set/clear writes selected bit
// - Transfer store copies source bit to T
// - Transfer load copies T into destination bit
// - Carry set/clear touches carry only
// - Negative set/clear touches negative only
// - Zero set/clear touches zero only
// - Interrupt enable sets I, disable clears
// - Sign set writes one into S
// - Sign clear writes zero into S
module bsfe_exec_unit #(
  parameter int RF_AW = 5,
  parameter int IO_AW = 5
) (
  input wire logic CLK_SYS_I,
  input wire logic NRST_I,
  input wire logic OP_VALID_I,
  input wire bsfe_pkg::bsfe_op_t OP_CODE_I,
  input wire logic [RF_AW-1:0] DST_ADDR_I,
  input wire logic [7:0] DST_DATA_I,
  input wire logic [7:0] SRC_DATA_I,
  input wire logic [2:0] BIT_SEL_I,
  input wire logic [7:0] STACK_DATA_I,
  input wire logic [IO_AW-1:0] IO_ADDR_I,
  input wire logic [7:0] IO_DATA_I,
  output logic REG_WE_O,
  output logic [RF_AW-1:0] REG_ADDR_O,
  output logic [7:0] REG_DATA_O,
  output logic IO_WE_O,
  output logic [IO_AW-1:0] IO_ADDR_O,
  output logic [7:0] IO_DATA_O,
  output logic [7:0] STATUS_O,
  output logic DONE_O,
  output logic ILLEGAL_O
);
  import bsfe_pkg::*;
  `include "bsfe_params.svh"

  //--------------------------------------------------------------------
  // Declarations
  //--------------------------------------------------------------------
  bsfe_shift_if sh_link ();
  bsfe_state_t state_r;
  bsfe_state_t state_nxt;
  logic take;
  logic [7:0] bit_mask;
  logic [7:0] status_register_r;
  logic [7:0] status_register_nxt;
  logic flag_hit;
  logic [2:0] flag_idx;
  logic flag_val;
  logic is_shift;
  logic known_op;
  logic reg_we_r;
  logic reg_we_nxt;
  logic [RF_AW-1:0] reg_addr_r;
  logic [RF_AW-1:0] reg_addr_nxt;
  logic [7:0] reg_data_r;
  logic [7:0] reg_data_nxt;
  logic io_we_r;
  logic io_we_nxt;
  logic [IO_AW-1:0] io_addr_r;
  logic [IO_AW-1:0] io_addr_nxt;
  logic [7:0] io_data_r;
  logic [7:0] io_data_nxt;
  logic done_r;
  logic illegal_r;

  // No stall source exists, so every valid cycle is taken
  assign take = OP_VALID_I;

  //--------------------------------------------------------------------
  // Bit select decode
  //--------------------------------------------------------------------
  // One-hot mask of the selected bit position
  for (genvar i = 0; i < `BSFE_DW; i++) begin : g_mask
    assign bit_mask[i] = (BIT_SEL_I == 3'(i));
  end

  //--------------------------------------------------------------------
  // Shifter link
  //--------------------------------------------------------------------
  // Map opcodes onto shifter operations
  always_comb begin
    sh_link.kind = sh_pass;
    is_shift = 1'b1;
    case (OP_CODE_I)
      logical_left_shift_op: sh_link.kind = sh_lsl;
      logical_right_shift_op: sh_link.kind = sh_lsr;
      rotate_left_carry_op: sh_link.kind = sh_rol;
      rotate_right_carry_op: sh_link.kind = sh_ror;
      arith_right_shift_op: sh_link.kind = sh_asr;
      nibble_swap_op: sh_link.kind = sh_swap;
      default: is_shift = 1'b0;
    endcase
  end

  // Rotates draw on the carry held here
  assign sh_link.operand = DST_DATA_I;
  assign sh_link.carry_in = status_register_r[`BSFE_C_BIT];

  bsfe_shift u_shift (
    .sh (sh_link)
  );

  //--------------------------------------------------------------------
  // Flag instruction decode
  //--------------------------------------------------------------------
  // Dedicated flag ops reduce to one bit index and one value
  always_comb begin
    flag_hit = 1'b1;
    flag_idx = 3'(`BSFE_C_BIT);
    flag_val = 1'b0;
    case (OP_CODE_I)
      status_bit_set_op: begin
        flag_idx = BIT_SEL_I;
        flag_val = 1'b1;
      end
      status_bit_clear_op: begin
        flag_idx = BIT_SEL_I;
      end
      carry_set_op: begin
        flag_val = 1'b1;
      end
      carry_clear_op: begin
        flag_idx = 3'(`BSFE_C_BIT);
      end
      negative_set_op: begin
        flag_idx = 3'(`BSFE_N_BIT);
        flag_val = 1'b1;
      end
      negative_clear_op: begin
        flag_idx = 3'(`BSFE_N_BIT);
      end
      zero_set_op: begin
        flag_idx = 3'(`BSFE_Z_BIT);
        flag_val = 1'b1;
      end
      zero_clear_op: begin
        flag_idx = 3'(`BSFE_Z_BIT);
      end
      interrupt_enable_op: begin
        flag_idx = 3'(`BSFE_I_BIT);
        flag_val = 1'b1;
      end
      interrupt_disable_op: begin
        flag_idx = 3'(`BSFE_I_BIT);
      end
      sign_set_op: begin
        flag_idx = 3'(`BSFE_S_BIT);
        flag_val = 1'b1;
      end
      sign_clear_op: begin
        flag_idx = 3'(`BSFE_S_BIT);
      end
      default: begin
        flag_hit = 1'b0;
      end
    endcase
  end

  // Opcodes outside the group are flagged, not executed
  assign known_op = is_shift || flag_hit ||
                    (OP_CODE_I == stack_pull_op) ||
                    (OP_CODE_I == io_bit_set_op) ||
                    (OP_CODE_I == io_bit_clear_op) ||
                    (OP_CODE_I == transfer_bit_store_op) ||
                    (OP_CODE_I == transfer_bit_load_op);

  //--------------------------------------------------------------------
  // Status register
  //--------------------------------------------------------------------
  // Next status; untouched bits keep their value
  always_comb begin
    status_register_nxt = status_register_r;
    if (take) begin
      if (flag_hit) begin
        status_register_nxt[flag_idx] = flag_val;
      end
      if (is_shift && sh_link.flags_upd) begin
        status_register_nxt[`BSFE_C_BIT] = sh_link.carry_out;
        status_register_nxt[`BSFE_Z_BIT] = sh_link.zero;
        status_register_nxt[`BSFE_N_BIT] = sh_link.negative;
        status_register_nxt[`BSFE_V_BIT] = sh_link.overflow;
      end
      if (OP_CODE_I == transfer_bit_store_op) begin
        status_register_nxt[`BSFE_T_BIT] = |(SRC_DATA_I & bit_mask);
      end
    end
  end

  // Status holds its value between instructions
  always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
    if (!NRST_I) begin
      status_register_r <= `BSFE_STATUS_REGISTER_RST;
    end else begin
      status_register_r <= status_register_nxt;
    end
  end

  //--------------------------------------------------------------------
  // Register file write
  //--------------------------------------------------------------------
  // Destination byte; the read-modify-write uses the current value
  always_comb begin
    reg_we_nxt = 1'b0;
    reg_addr_nxt = reg_addr_r;
    reg_data_nxt = reg_data_r;
    if (take) begin
      case (OP_CODE_I)
        stack_pull_op: begin
          reg_we_nxt = 1'b1;
          reg_addr_nxt = DST_ADDR_I;
          reg_data_nxt = STACK_DATA_I;
        end
        transfer_bit_load_op: begin
          reg_we_nxt = 1'b1;
          reg_addr_nxt = DST_ADDR_I;
          reg_data_nxt = status_register_r[`BSFE_T_BIT] ?
                         (DST_DATA_I | bit_mask) :
                         (DST_DATA_I & ~bit_mask);
        end
        default: begin
          if (is_shift) begin
            reg_we_nxt = 1'b1;
            reg_addr_nxt = DST_ADDR_I;
            reg_data_nxt = sh_link.result;
          end
        end
      endcase
    end
  end

  // Strobe is one cycle; address and data stay until the next write
  always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
    if (!NRST_I) begin
      reg_we_r <= 1'b0;
      reg_addr_r <= '0;
      reg_data_r <= `BSFE_BYTE_ZERO;
    end else begin
      reg_we_r <= reg_we_nxt;
      reg_addr_r <= reg_addr_nxt;
      reg_data_r <= reg_data_nxt;
    end
  end

  //--------------------------------------------------------------------
  // I/O register write
  //--------------------------------------------------------------------
  // Single-bit change; other bits come back as read
  always_comb begin
    io_we_nxt = 1'b0;
    io_addr_nxt = io_addr_r;
    io_data_nxt = io_data_r;
    if (take) begin
      if (OP_CODE_I == io_bit_set_op) begin
        io_we_nxt = 1'b1;
        io_addr_nxt = IO_ADDR_I;
        io_data_nxt = IO_DATA_I | bit_mask;
      end else if (OP_CODE_I == io_bit_clear_op) begin
        io_we_nxt = 1'b1;
        io_addr_nxt = IO_ADDR_I;
        io_data_nxt = IO_DATA_I & ~bit_mask;
      end
    end
  end

  // Limitation: bits that hardware changes meanwhile are overwritten
  always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
    if (!NRST_I) begin
      io_we_r <= 1'b0;
      io_addr_r <= '0;
      io_data_r <= `BSFE_BYTE_ZERO;
    end else begin
      io_we_r <= io_we_nxt;
      io_addr_r <= io_addr_nxt;
      io_data_r <= io_data_nxt;
    end
  end

  //--------------------------------------------------------------------
  // Commit sequencer
  //--------------------------------------------------------------------
  // Commit state marks the cycle after an opcode was taken
  always_comb begin
    case (state_r)
      st_idle: state_nxt = take ? st_commit : st_idle;
      st_commit: state_nxt = take ? st_commit : st_idle;
      default: state_nxt = st_idle;
    endcase
  end

  // Sequencer state
  always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
    if (!NRST_I) begin
      state_r <= st_idle;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Done and illegal pulses, registered with the strobes
  always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
    if (!NRST_I) begin
      done_r <= 1'b0;
      illegal_r <= 1'b0;
    end else begin
      done_r <= take;
      illegal_r <= take && !known_op;
    end
  end

  //--------------------------------------------------------------------
  // Outputs
  //--------------------------------------------------------------------
  assign REG_WE_O = reg_we_r;
  assign REG_ADDR_O = reg_addr_r;
  assign REG_DATA_O = reg_data_r;
  assign IO_WE_O = io_we_r;
  assign IO_ADDR_O = io_addr_r;
  assign IO_DATA_O = io_data_r;
  assign STATUS_O = status_register_r;
  assign DONE_O = done_r && (state_r == st_commit);
  assign ILLEGAL_O = illegal_r;
endmodule : bsfe_exec_unit

// [logic/bsfe_params.svh]
// Named constants of the bit, shift and flag execution unit.
// Assumes inclusion by bare name from each design file that needs it.
`ifndef BSFE_PARAMS_SVH
`define BSFE_PARAMS_SVH
// Data path width and sign bit
`define BSFE_DW 8
`define BSFE_MSB 7
// Nibble width for the exchange
`define BSFE_NIB 4
// Status register bit positions
`define BSFE_C_BIT 0
`define BSFE_Z_BIT 1
`define BSFE_N_BIT 2
`define BSFE_V_BIT 3
`define BSFE_S_BIT 4
`define BSFE_T_BIT 6
`define BSFE_I_BIT 7
// Reset and fill values
`define BSFE_STATUS_REGISTER_RST 8'h00
`define BSFE_BYTE_ZERO 8'h00
`endif

// [logic/bsfe_pkg.sv]
// Types of the bit, shift and flag execution unit.
// Assumes the decoder drives opcodes of bsfe_op_t.
package bsfe_pkg;
  // Instruction group decoded upstream
  typedef enum logic [4:0] {
    nop_op = 5'h00,
    stack_pull_op = 5'h01,
    io_bit_set_op = 5'h02,
    io_bit_clear_op = 5'h03,
    logical_left_shift_op = 5'h04,
    logical_right_shift_op = 5'h05,
    rotate_left_carry_op = 5'h06,
    rotate_right_carry_op = 5'h07,
    arith_right_shift_op = 5'h08,
    nibble_swap_op = 5'h09,
    status_bit_set_op = 5'h0A,
    status_bit_clear_op = 5'h0B,
    transfer_bit_store_op = 5'h0C,
    transfer_bit_load_op = 5'h0D,
    carry_set_op = 5'h0E,
    carry_clear_op = 5'h0F,
    negative_set_op = 5'h10,
    negative_clear_op = 5'h11,
    zero_set_op = 5'h12,
    zero_clear_op = 5'h13,
    interrupt_enable_op = 5'h14,
    interrupt_disable_op = 5'h15,
    sign_set_op = 5'h16,
    sign_clear_op = 5'h17
  } bsfe_op_t;
  // Operation of the shifter
  typedef enum logic [2:0] {
    sh_pass = 3'h0,
    sh_lsl = 3'h1,
    sh_lsr = 3'h2,
    sh_rol = 3'h3,
    sh_ror = 3'h4,
    sh_asr = 3'h5,
    sh_swap = 3'h6
  } bsfe_shift_t;
  // Commit sequencer states, one-hot
  typedef enum logic [1:0] {
    st_idle = 2'h1,
    st_commit = 2'h2
  } bsfe_state_t;
endpackage : bsfe_pkg

// [logic/bsfe_shift_if.sv]
// Link between the execution core and its shifter.
// Assumes both ends sit on the same clock; the path is combinational.
`timescale 1ns/1ps
interface bsfe_shift_if;
  import bsfe_pkg::*;
  bsfe_shift_t kind;
  logic [7:0] operand;
  logic carry_in;
  logic [7:0] result;
  logic carry_out;
  logic zero;
  logic negative;
  logic overflow;
  logic flags_upd;
  modport core (output kind, operand, carry_in,
                input result, carry_out, zero, negative, overflow, flags_upd);
  modport unit (input kind, operand, carry_in,
                output result, carry_out, zero, negative, overflow, flags_upd);
endinterface : bsfe_shift_if

// [logic/bsfe_shift.sv]
// Combinational shifter, rotator and nibble exchanger with flag results.
// Assumes the core registers everything it takes from here.
`timescale 1ns/1ps
module bsfe_shift (
  bsfe_shift_if.unit sh
);
  import bsfe_pkg::*;
  `include "bsfe_params.svh"

  logic [7:0] res;
  logic cout;
  logic upd;

  // Result and bit shifted out
  always_comb begin
    res = sh.operand;
    cout = sh.carry_in;
    upd = 1'b1;
    case (sh.kind)
      sh_lsl: begin
        {cout, res} = {sh.operand, 1'b0};
      end
      sh_lsr: begin
        {res, cout} = {1'b0, sh.operand};
      end
      sh_rol: begin
        {cout, res} = {sh.operand, sh.carry_in};
      end
      sh_ror: begin
        {res, cout} = {sh.carry_in, sh.operand};
      end
      sh_asr: begin
        {res, cout} = {sh.operand[`BSFE_MSB], sh.operand};
      end
      sh_swap: begin
        res = {sh.operand[`BSFE_NIB-1:0], sh.operand[`BSFE_DW-1:`BSFE_NIB]};
        upd = 1'b0;
      end
      default: begin
        upd = 1'b0;
      end
    endcase
  end

  // Flags follow result and carry out; overflow is sign xor carry
  assign sh.result = res;
  assign sh.carry_out = cout;
  assign sh.zero = (res == `BSFE_BYTE_ZERO);
  assign sh.negative = res[`BSFE_MSB];
  assign sh.overflow = res[`BSFE_MSB] ^ cout;
  assign sh.flags_upd = upd;
endmodule : bsfe_shift

// [bench/bsfe_far_model.sv]
// Far-side model: register file and I/O space behind the unit.
// Assumes write strobes land at the edge after the unit raises them.
`timescale 1ns/1ps
module bsfe_far_model #(
  parameter int RF_AW = 5,
  parameter int IO_AW = 5
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic reg_we_i,
  input wire logic [RF_AW-1:0] reg_addr_i,
  input wire logic [7:0] reg_data_i,
  input wire logic io_we_i,
  input wire logic [IO_AW-1:0] io_addr_i,
  input wire logic [7:0] io_data_i,
  input wire logic [RF_AW-1:0] dst_addr_i,
  input wire logic [IO_AW-1:0] io_rd_addr_i,
  output logic [7:0] dst_data_o,
  output logic [7:0] io_rd_data_o
);
  logic [7:0] rf_r [2**RF_AW];
  logic [7:0] io_r [2**IO_AW];
  // Registers stay unknown until written, so stale reads show up
  always_ff @(posedge clk_i) begin
    if (reg_we_i) begin
      rf_r[reg_addr_i] <= reg_data_i;
    end
  end
  // I/O space starts from a fixed pattern
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      for (int i = 0; i < 2**IO_AW; i++) io_r[i] <= 8'h5A;
    end else if (io_we_i) begin
      io_r[io_addr_i] <= io_data_i;
    end
  end
  // Reads are combinational, as the decoder forwards them
  assign dst_data_o = rf_r[dst_addr_i];
  assign io_rd_data_o = io_r[io_rd_addr_i];
endmodule : bsfe_far_model

// [bench/bsfe_exec_unit_sva.sv]
// Checker for the execution unit, watching its top ports.
// Assumes it is bound onto every bsfe_exec_unit instance.
`timescale 1ns/1ps
module bsfe_exec_unit_sva #(
  parameter int RF_AW = 5,
  parameter int IO_AW = 5
) (
  input wire logic CLK_SYS_I,
  input wire logic NRST_I,
  input wire logic OP_VALID_I,
  input wire bsfe_pkg::bsfe_op_t OP_CODE_I,
  input wire logic [RF_AW-1:0] DST_ADDR_I,
  input wire logic [7:0] DST_DATA_I,
  input wire logic [2:0] BIT_SEL_I,
  input wire logic [7:0] STACK_DATA_I,
  input wire logic [7:0] IO_DATA_I,
  input wire logic REG_WE_O,
  input wire logic [RF_AW-1:0] REG_ADDR_O,
  input wire logic [7:0] REG_DATA_O,
  input wire logic IO_WE_O,
  input wire logic [7:0] IO_DATA_O,
  input wire logic [7:0] STATUS_O,
  input wire logic DONE_O,
  input wire logic ILLEGAL_O
);
  import bsfe_pkg::*;
  default clocking cb @(posedge CLK_SYS_I);
  endclocking
  default disable iff (!NRST_I);
  // Answers come exactly one cycle after a taken opcode
  a_done_pulse: assert property (OP_VALID_I |=> DONE_O)
    else $error("done pulse missing");
  a_idle_quiet: assert property (!OP_VALID_I |=> !DONE_O && !REG_WE_O && !IO_WE_O)
    else $error("output pulse without opcode");
  a_pop_write: assert property (
    OP_VALID_I && OP_CODE_I == stack_pull_op |=> REG_WE_O
    && REG_ADDR_O == $past(DST_ADDR_I) && REG_DATA_O == $past(STACK_DATA_I))
    else $error("pop write wrong");
  a_io_set: assert property (
    OP_VALID_I && OP_CODE_I == io_bit_set_op |=> IO_WE_O
    && IO_DATA_O == ($past(IO_DATA_I) | (8'h01 << $past(BIT_SEL_I))))
    else $error("io bit set wrong");
  a_io_clear: assert property (
    OP_VALID_I && OP_CODE_I == io_bit_clear_op |=> IO_WE_O
    && IO_DATA_O == ($past(IO_DATA_I) & ~(8'h01 << $past(BIT_SEL_I))))
    else $error("io bit clear wrong");
  a_lsl_result: assert property (
    OP_VALID_I && OP_CODE_I == logical_left_shift_op |=> REG_WE_O
    && REG_DATA_O == {$past(DST_DATA_I[6:0]), 1'b0} && STATUS_O[0] == $past(DST_DATA_I[7]))
    else $error("left shift wrong");
  a_ror_carry: assert property (
    OP_VALID_I && OP_CODE_I == rotate_right_carry_op
    |=> REG_DATA_O == {$past(STATUS_O[0]), $past(DST_DATA_I[7:1])}
    && STATUS_O[0] == $past(DST_DATA_I[0]))
    else $error("right rotate wrong");
  a_swap_noflag: assert property (
    OP_VALID_I && OP_CODE_I == nibble_swap_op |=> $stable(STATUS_O)
    && REG_DATA_O == {$past(DST_DATA_I[3:0]), $past(DST_DATA_I[7:4])})
    else $error("nibble exchange wrong");
  a_sign_set: assert property (
    OP_VALID_I && OP_CODE_I == sign_set_op |=> STATUS_O == ($past(STATUS_O) | 8'h10))
    else $error("sign set wrong");
  a_illegal_quiet: assert property (OP_VALID_I && OP_CODE_I == nop_op
    |=> ILLEGAL_O && !REG_WE_O && !IO_WE_O && $stable(STATUS_O))
    else $error("idle opcode had effect");
endmodule : bsfe_exec_unit_sva

bind bsfe_exec_unit bsfe_exec_unit_sva #(.RF_AW(RF_AW), .IO_AW(IO_AW)) sva_inst (
  .CLK_SYS_I(CLK_SYS_I), .NRST_I(NRST_I), .OP_VALID_I(OP_VALID_I), .OP_CODE_I(OP_CODE_I),
  .DST_ADDR_I(DST_ADDR_I), .DST_DATA_I(DST_DATA_I), .BIT_SEL_I(BIT_SEL_I),
  .STACK_DATA_I(STACK_DATA_I), .IO_DATA_I(IO_DATA_I), .REG_WE_O(REG_WE_O),
  .REG_ADDR_O(REG_ADDR_O), .REG_DATA_O(REG_DATA_O), .IO_WE_O(IO_WE_O),
  .IO_DATA_O(IO_DATA_O), .STATUS_O(STATUS_O), .DONE_O(DONE_O), .ILLEGAL_O(ILLEGAL_O));

// [bench/bsfe_exec_unit_tb.sv]
// Self-checking bench for the bit, shift and flag execution unit.
// Assumes the far-side model serves register and I/O reads.
`timescale 1ns/1ps
module bsfe_exec_unit_tb;
  import bsfe_pkg::*;
  logic clk = 1'b0;
  logic nrst;
  logic vld = 1'b0;
  bsfe_op_t opc = nop_op;
  logic [4:0] adr = 5'h00;
  logic [2:0] bsel = 3'h0;
  logic [7:0] stk = 8'h00;
  logic [7:0] dst_d, io_d, reg_d, io_o, st;
  logic [4:0] reg_a, io_a;
  logic reg_we, io_we, done, ill;
  logic [7:0] sexp = 8'h00;
  int num_errors = 0;
  int tests_run = 0;
  always #5 clk = ~clk;
  bsfe_exec_unit #(.RF_AW(5), .IO_AW(5)) bsfe_exec_unit_inst (.CLK_SYS_I(clk), .NRST_I(nrst),
    .OP_VALID_I(vld), .OP_CODE_I(opc), .DST_ADDR_I(adr), .DST_DATA_I(dst_d),
    .SRC_DATA_I(stk), .BIT_SEL_I(bsel), .STACK_DATA_I(stk), .IO_ADDR_I(adr),
    .IO_DATA_I(io_d), .REG_WE_O(reg_we), .REG_ADDR_O(reg_a), .REG_DATA_O(reg_d),
    .IO_WE_O(io_we), .IO_ADDR_O(io_a), .IO_DATA_O(io_o), .STATUS_O(st),
    .DONE_O(done), .ILLEGAL_O(ill));
  bsfe_far_model #(.RF_AW(5), .IO_AW(5)) bsfe_far_model_inst (.clk_i(clk), .nrst_i(nrst),
    .reg_we_i(reg_we), .reg_addr_i(reg_a), .reg_data_i(reg_d), .io_we_i(io_we),
    .io_addr_i(io_a), .io_data_i(io_o), .dst_addr_i(adr), .io_rd_addr_i(adr),
    .dst_data_o(dst_d), .io_rd_data_o(io_d));
  // ----------------------------------------
  // Shared helpers
  // ----------------------------------------
  task chk(input logic [7:0] seen, input logic [7:0] want);
    tests_run++;
    if (seen !== want) begin
      num_errors++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, want);
    end
  endtask : chk
  // One opcode, then a gap cycle so the model has stored any write
  task do_op(input bsfe_op_t op, input logic [4:0] a, input logic [2:0] b, input logic [7:0] x);
    @(posedge clk);
    vld <= 1'b1;
    opc <= op;
    adr <= a;
    bsel <= b;
    stk <= x;
    @(posedge clk);
    vld <= 1'b0;
    #1;
    chk(done, 1'b1);
  endtask : do_op
  task pop(input logic [4:0] a, input logic [7:0] x);
    do_op(stack_pull_op, a, 3'h0, x);
    chk({reg_we, reg_a}, {2'b01, a});
    chk(reg_d, x);
  endtask : pop
  // Carry-out above the result byte
  function automatic logic [8:0] exp_sh(input bsfe_op_t op, input logic [7:0] d, input logic c);
    case (op)
      logical_left_shift_op: return {d, 1'b0};
      logical_right_shift_op: return {d[0], 1'b0, d[7:1]};
      rotate_left_carry_op: return {d, c};
      rotate_right_carry_op: return {d[0], c, d[7:1]};
      arith_right_shift_op: return {d[0], d[7], d[7:1]};
      default: return {c, d[3:0], d[7:4]};
    endcase
  endfunction : exp_sh
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_flags;
    bsfe_op_t ops[10];
    logic [7:0] msk[5];
    ops = '{carry_clear_op, carry_set_op, negative_clear_op, negative_set_op, zero_clear_op,
      zero_set_op, interrupt_disable_op, interrupt_enable_op, sign_clear_op, sign_set_op};
    msk = '{8'h01, 8'h04, 8'h02, 8'h80, 8'h10};
    for (int b = 0; b < 8; b++) begin
      do_op(status_bit_set_op, 5'h00, b[2:0], 8'h00);
      sexp[b] = 1'b1;
      chk(st, sexp);
    end
    // Start from all ones so a clear that spills onto a neighbour shows
    foreach (ops[i]) begin
      do_op(ops[i], 5'h00, 3'h0, 8'h00);
      sexp = i[0] ? (sexp | msk[i/2]) : (sexp & ~msk[i/2]);
      chk(st, sexp);
      chk({reg_we, io_we}, 2'b00);
    end
    for (int b = 7; b >= 0; b--) begin
      do_op(status_bit_clear_op, 5'h00, b[2:0], 8'h00);
      sexp[b] = 1'b0;
      chk(st, sexp);
    end
  endtask : t_flags
  task t_shift;
    bsfe_op_t ops[6];
    logic [7:0] vals[3];
    logic [8:0] r;
    ops = '{logical_left_shift_op, logical_right_shift_op, rotate_left_carry_op,
      rotate_right_carry_op, arith_right_shift_op, nibble_swap_op};
    vals = '{8'h81, 8'h80, 8'h01};
    foreach (ops[i]) begin
      foreach (vals[j]) begin
        for (int c = 0; c < 2; c++) begin
          do_op(c ? carry_set_op : carry_clear_op, 5'h00, 3'h0, 8'h00);
          sexp[0] = c[0];
          chk(st, sexp);
          pop(5'h02, vals[j]);
          do_op(ops[i], 5'h02, 3'h0, 8'h00);
          r = exp_sh(ops[i], vals[j], c[0]);
          if (ops[i] != nibble_swap_op) sexp[3:0] = {r[7] ^ r[8], r[7], r[7:0] == 8'h00, r[8]};
          chk(reg_d, r[7:0]);
          chk(st, sexp);
        end
      end
    end
  endtask : t_shift
  task t_xfer(input logic [7:0] s, input logic [2:0] b, input logic [7:0] d, input logic [2:0] lb);
    do_op(transfer_bit_store_op, 5'h00, b, s);
    sexp[6] = s[b];
    chk(st, sexp);
    pop(5'h04, d);
    do_op(transfer_bit_load_op, 5'h04, lb, 8'h00);
    d[lb] = s[b];
    chk(reg_d, d);
    chk(st, sexp);
  endtask : t_xfer
  task t_io;
    do_op(io_bit_set_op, 5'h06, 3'h7, 8'h00);
    chk({io_we, io_a}, {2'b01, 5'h06});
    chk(io_o, 8'hDA);
    do_op(io_bit_clear_op, 5'h06, 3'h1, 8'h00);
    chk(io_o, 8'hD8);
    chk(reg_we, 1'b0);
    chk(st, sexp);
  endtask : t_io
  task t_bad;
    // Pulse bits kept apart from status so none is cut off
    do_op(nop_op, 5'h01, 3'h0, 8'h00);
    chk({5'h00, ill, reg_we, io_we}, 8'h04);
    chk(st, sexp);
    do_op(bsfe_op_t'(5'h1F), 5'h01, 3'h0, 8'h00);
    chk({5'h00, ill, reg_we, io_we}, 8'h04);
    chk(st, sexp);
  endtask : t_bad
  task wrap_up;
    $display("checks %0d, mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : wrap_up
  // Main sequence; status is all zero while reset holds
  initial begin
    // Unknown to low is a falling edge, so the async reset really engages
    nrst <= 1'b0;
    repeat (8) @(posedge clk);
    chk(st, 8'h00);
    nrst <= 1'b1;
    t_flags();
    t_shift();
    t_xfer(8'h20, 3'h5, 8'h00, 3'h7);
    t_xfer(8'hDF, 3'h5, 8'hFF, 3'h0);
    t_io();
    t_bad();
    wrap_up();
  end
  // Watchdog well beyond the roughly 300 cycles the run needs
  initial begin
    #200000;
    num_errors++;
    wrap_up();
  end
endmodule : bsfe_exec_unit_tb
